// *** adc_backend_detect_cal_testgen.sv ***
// Overrange detector, calibration gate and test-pattern generator.
// Assumes samples and decoded byte writes arrive on clk_sys already.
`timescale 1ns/1ps
`default_nettype none
module adc_backend_detect_cal_testgen #(
    parameter int SAMPLE_W = 12,
    parameter int CAL_LOG2_N = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire adc_backend_pkg::sample_t sample_in,
    input wire adc_backend_pkg::reg_wr_t reg_wr,
    input wire logic [adc_backend_pkg::ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data,
    output adc_backend_pkg::sample_t data_out,
    output logic overrange_flag,
    output logic cal_update,
    output logic [15:0] cal_coeff
);
    import adc_backend_pkg::*;

    localparam int ACC_W = 12 + CAL_LOG2_N;

    if (SAMPLE_W != 12) begin : g_bad_width
        $error("Only 12-bit samples are supported");
    end
    if (CAL_LOG2_N < 1 || CAL_LOG2_N > 20) begin : g_bad_window
        $error("Calibration window exponent must be 1 to 20");
    end

    // ****************************************
    // Control registers
    // ****************************************
    logic [7:0] test_sel_reg, test_sel_next;
    logic [7:0] cal_ctrl_reg, cal_ctrl_next;
    logic [7:0] format_reg, format_next;
    logic [15:0] upper_reg, upper_next;
    logic [15:0] lower_reg, lower_next;
    logic [15:0] dwell_reg, dwell_next;
    logic [15:0] cal_thr_reg, cal_thr_next;
    logic [7:0] user_reg [0:7];
    logic [7:0] user_next [0:7];
    logic [7:0] rd_reg, rd_next;
    logic blocked_reg, blocked_next;
    logic flag_reg, flag_next;
    logic [2:0] user_wr_idx;

    assign user_wr_idx = 3'(reg_wr.addr - OFF_USER_FIRST);

    always_comb begin
        test_sel_next = test_sel_reg;
        cal_ctrl_next = cal_ctrl_reg;
        format_next = format_reg;
        upper_next = upper_reg;
        lower_next = lower_reg;
        dwell_next = dwell_reg;
        cal_thr_next = cal_thr_reg;
        user_next = user_reg;
        if (reg_wr.en) begin
            // Each byte lands in its own half of the 16-bit value
            case (reg_wr.addr)
                OFF_TEST_SEL: test_sel_next = reg_wr.data;
                OFF_CAL_CTRL: cal_ctrl_next = reg_wr.data;
                OFF_FORMAT: format_next = reg_wr.data;
                OFF_FD_UPPER_LO: upper_next[7:0] = reg_wr.data;
                OFF_FD_UPPER_HI: upper_next[15:8] = reg_wr.data;
                OFF_FD_LOWER_LO: lower_next[7:0] = reg_wr.data;
                OFF_FD_LOWER_HI: lower_next[15:8] = reg_wr.data;
                OFF_FD_DWELL_LO: dwell_next[7:0] = reg_wr.data;
                OFF_FD_DWELL_HI: dwell_next[15:8] = reg_wr.data;
                OFF_CAL_THR_LO: cal_thr_next[7:0] = reg_wr.data;
                OFF_CAL_THR_HI: cal_thr_next[15:8] = reg_wr.data;
                default: begin
                    if (reg_wr.addr >= OFF_USER_FIRST &&
                        reg_wr.addr <= OFF_USER_LAST) begin
                        user_next[user_wr_idx] = reg_wr.data;
                    end
                end
            endcase
        end
    end

    always_comb begin
        rd_next = 8'h00;
        case (rd_addr)
            OFF_TEST_SEL: rd_next = test_sel_reg;
            OFF_CAL_CTRL: rd_next = cal_ctrl_reg;
            OFF_FORMAT: rd_next = format_reg;
            OFF_FD_UPPER_LO: rd_next = upper_reg[7:0];
            OFF_FD_UPPER_HI: rd_next = upper_reg[15:8];
            OFF_FD_LOWER_LO: rd_next = lower_reg[7:0];
            OFF_FD_LOWER_HI: rd_next = lower_reg[15:8];
            OFF_FD_DWELL_LO: rd_next = dwell_reg[7:0];
            OFF_FD_DWELL_HI: rd_next = dwell_reg[15:8];
            OFF_CAL_THR_LO: rd_next = cal_thr_reg[7:0];
            OFF_CAL_THR_HI: rd_next = cal_thr_reg[15:8];
            OFF_STATUS: begin
                rd_next[STAT_FLAG_BIT] = flag_reg;
                rd_next[STAT_BLOCKED_BIT] = blocked_reg;
            end
            default: begin
                if (rd_addr >= OFF_USER_FIRST && rd_addr <= OFF_USER_LAST) begin
                    rd_next = user_reg[3'(rd_addr - OFF_USER_FIRST)];
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            test_sel_reg <= TEST_SEL_RESET;
            cal_ctrl_reg <= CAL_CTRL_RESET;
            format_reg <= FORMAT_RESET;
            upper_reg <= FD_UPPER_RESET;
            lower_reg <= FD_LOWER_RESET;
            dwell_reg <= FD_DWELL_RESET;
            cal_thr_reg <= CAL_THR_RESET;
            for (int i = 0; i < 8; i++) begin
                user_reg[i] <= 8'h00;
            end
            rd_reg <= 8'h00;
        end else begin
            test_sel_reg <= test_sel_next;
            cal_ctrl_reg <= cal_ctrl_next;
            format_reg <= format_next;
            upper_reg <= upper_next;
            lower_reg <= lower_next;
            dwell_reg <= dwell_next;
            cal_thr_reg <= cal_thr_next;
            user_reg <= user_next;
            rd_reg <= rd_next;
        end
    end

    // ****************************************
    // Sample intake and magnitude
    // ****************************************
    sample_t in_reg;
    logic [11:0] mag;
    logic [15:0] mag16;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            in_reg <= '0;
        end else begin
            in_reg <= sample_in;
        end
    end

    // Negative full scale gives 2048, which still fits in 12 unsigned bits
    assign mag = in_reg.data[11] ? 12'(~in_reg.data + 12'h001) : in_reg.data;
    assign mag16 = {4'h0, mag};

    // ****************************************
    // Overrange detector
    // ****************************************
    logic [16:0] dwell_cnt_reg, dwell_cnt_next;
    logic [16:0] dwell_inc;

    assign dwell_inc = dwell_cnt_reg + 17'h00001;

    always_comb begin
        flag_next = flag_reg;
        dwell_cnt_next = dwell_cnt_reg;
        if (in_reg.valid) begin
            if (mag16 > upper_reg) begin
                flag_next = 1'b1;
                dwell_cnt_next = '0;
            end else if (flag_reg) begin
                if (mag16 >= lower_reg) begin
                    dwell_cnt_next = '0;
                end else if (dwell_inc > {1'b0, dwell_reg}) begin
                    flag_next = 1'b0;
                    dwell_cnt_next = '0;
                end else begin
                    dwell_cnt_next = dwell_inc;
                end
            end
        end
    end

    // ****************************************
    // Calibration gate
    // ****************************************
    logic [ACC_W-1:0] acc_reg, acc_next, acc_sum;
    logic [CAL_LOG2_N-1:0] cal_cnt_reg, cal_cnt_next;
    logic [15:0] coeff_reg, coeff_next;
    logic upd_reg, upd_next;
    logic [11:0] avg;
    logic [15:0] avg_code;

    assign acc_sum = acc_reg + ACC_W'(mag);
    assign avg = acc_sum[ACC_W-1:CAL_LOG2_N];
    // Scaling to threshold codes keeps the compare exact with no divider
    assign avg_code = 16'(avg) << CAL_SCALE_SH;

    always_comb begin
        acc_next = acc_reg;
        cal_cnt_next = cal_cnt_reg;
        coeff_next = coeff_reg;
        upd_next = 1'b0;
        blocked_next = blocked_reg;
        if (in_reg.valid) begin
            acc_next = acc_sum;
            cal_cnt_next = cal_cnt_reg + 1'b1;
            if (&cal_cnt_reg) begin
                acc_next = '0;
                if (!cal_ctrl_reg[CAL_GATE_BIT] || avg_code > cal_thr_reg) begin
                    coeff_next = avg_code;
                    upd_next = 1'b1;
                    blocked_next = 1'b0;
                end else begin
                    blocked_next = 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Test-pattern generator
    // ****************************************
    logic [22:0] pn_reg, pn_next;
    logic [11:0] ramp_reg, ramp_next;
    logic phase_reg, phase_next;
    logic [1:0] uidx_reg, uidx_next;
    logic [15:0] user_word [0:3];
    logic [11:0] raw;
    logic fmt_ok;
    sample_t out_reg, out_next;

    for (genvar k = 0; k < 4; k++) begin : g_user
        assign user_word[k] = {user_reg[2*k+1], user_reg[2*k]};
    end

    always_comb begin
        pn_next = pn_reg;
        ramp_next = ramp_reg;
        phase_next = phase_reg;
        uidx_next = uidx_reg;
        if (in_reg.valid) begin
            pn_next = {pn_reg[21:0], pn_reg[22] ^ pn_reg[PN_TAP]};
            ramp_next = ramp_reg + 12'h001;
            phase_next = !phase_reg;
            uidx_next = uidx_reg + 2'h1;
        end
    end

    always_comb begin
        raw = in_reg.data;
        fmt_ok = 1'b1;
        case (test_sel_reg[3:0])
            TM_OFF: raw = in_reg.data;
            TM_MID: raw = PAT_ZERO;
            TM_POS_FS: raw = PAT_POS_FS;
            TM_NEG_FS: raw = PAT_NEG_FS;
            TM_CHECKER: begin
                raw = phase_reg ? PAT_CHECK_B : PAT_CHECK_A;
                fmt_ok = 1'b0;
            end
            TM_PN_LONG: raw = pn_reg[22:11];
            TM_TOGGLE: begin
                raw = phase_reg ? PAT_ZERO : PAT_ONES;
                fmt_ok = 1'b0;
            end
            TM_USER: raw = user_word[uidx_reg][15:4];
            TM_RAMP: begin
                raw = ramp_reg;
                fmt_ok = 1'b0;
            end
            default: raw = in_reg.data;
        endcase
        out_next.valid = in_reg.valid;
        out_next.data = (fmt_ok && format_reg[FMT_OFFSET_BIT]) ? raw ^ FMT_FLIP
                                                               : raw;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_reg <= 1'b0;
            dwell_cnt_reg <= '0;
            acc_reg <= '0;
            cal_cnt_reg <= '0;
            coeff_reg <= '0;
            upd_reg <= 1'b0;
            blocked_reg <= 1'b0;
            pn_reg <= PN_SEED;
            ramp_reg <= PAT_ZERO;
            phase_reg <= 1'b0;
            uidx_reg <= 2'h0;
            out_reg <= '0;
        end else begin
            flag_reg <= flag_next;
            dwell_cnt_reg <= dwell_cnt_next;
            acc_reg <= acc_next;
            cal_cnt_reg <= cal_cnt_next;
            coeff_reg <= coeff_next;
            upd_reg <= upd_next;
            blocked_reg <= blocked_next;
            pn_reg <= pn_next;
            ramp_reg <= ramp_next;
            phase_reg <= phase_next;
            uidx_reg <= uidx_next;
            out_reg <= out_next;
        end
    end

    assign rd_data = rd_reg;
    assign data_out = out_reg;
    assign overrange_flag = flag_reg;
    assign cal_update = upd_reg;
    assign cal_coeff = coeff_reg;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_sample_flow;
        sample_in.valid |-> ##2 data_out.valid;
    endproperty
    a_sample_flow: assert property (p_sample_flow)
        else $error("Sample did not reach the output in two cycles");

    property p_fd_set;
        in_reg.valid && mag16 > upper_reg |=> overrange_flag;
    endproperty
    a_fd_set: assert property (p_fd_set)
        else $error("Overrange flag missed a sample above upper threshold");

    property p_fd_clear;
        $fell(overrange_flag) |-> $past(in_reg.valid) &&
            $past(mag16) < $past(lower_reg) &&
            $past(dwell_cnt_reg) + 17'h00001 > {1'b0, $past(dwell_reg)};
    endproperty
    a_fd_clear: assert property (p_fd_clear)
        else $error("Overrange flag cleared before the dwell time");

    property p_dwell_restart;
        in_reg.valid && flag_reg && mag16 <= upper_reg &&
            mag16 >= lower_reg |=> dwell_cnt_reg == '0 && overrange_flag;
    endproperty
    a_dwell_restart: assert property (p_dwell_restart)
        else $error("Dwell count did not restart at the lower threshold");

    property p_cal_window;
        cal_update |-> $past(in_reg.valid) && $past(&cal_cnt_reg) &&
            acc_reg == '0;
    endproperty
    a_cal_window: assert property (p_cal_window)
        else $error("Coefficient update outside a window end");

    property p_cal_gate;
        cal_update && $past(cal_ctrl_reg[CAL_GATE_BIT]) |->
            cal_coeff > $past(cal_thr_reg);
    endproperty
    a_cal_gate: assert property (p_cal_gate)
        else $error("Coefficient updated below the calibration threshold");

    property p_cal_hold;
        !cal_update |-> $stable(cal_coeff) || $past(!rstn);
    endproperty
    a_cal_hold: assert property (p_cal_hold)
        else $error("Coefficient changed without an update");

    property p_thr_bytes;
        reg_wr.en && reg_wr.addr == OFF_CAL_THR_HI |=>
            cal_thr_reg[15:8] == $past(reg_wr.data) &&
            $stable(cal_thr_reg[7:0]);
    endproperty
    a_thr_bytes: assert property (p_thr_bytes)
        else $error("Threshold high byte not assembled");

    property p_code_range;
        cal_update |-> cal_coeff <= CAL_FULL_SCALE;
    endproperty
    a_code_range: assert property (p_code_range)
        else $error("Calibration code above full scale");

    property p_pos_fs;
        in_reg.valid && test_sel_reg[3:0] == TM_POS_FS &&
            !format_reg[FMT_OFFSET_BIT] |=> data_out.data == PAT_POS_FS;
    endproperty
    a_pos_fs: assert property (p_pos_fs)
        else $error("Positive full-scale pattern wrong");

    property p_ramp;
        in_reg.valid && test_sel_reg[3:0] == TM_RAMP |=>
            data_out.data == $past(ramp_reg);
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("Ramp pattern wrong or format applied");

    c_fd_cycle: cover property ($rose(overrange_flag) ##[1:200]
        $fell(overrange_flag));
    c_cal_update: cover property (cal_update);
    c_cal_blocked: cover property ($rose(blocked_reg));
    c_user_mode: cover property (data_out.valid &&
        test_sel_reg[3:0] == TM_USER);

endmodule
`default_nettype wire

// *** adc_backend_pkg.sv ***
// Constants, register map and carrier types for the converter back end.
// Assumes the serial control port has already decoded each byte write.
// Summary of operation
// - Each new sample is taken on the rising clock edge and later stages work on earlier samples at the same time.
// - The overrange flag rises as soon as a sample magnitude is above the upper threshold.
// - The overrange flag falls only after magnitudes stay below the lower threshold for more than the dwell time.
// - Calibration adds up every sample magnitude over a fixed sample count to estimate the average level.
// - At the end of each window the coefficient updates only if the estimate is above the threshold.
// - Threshold gating of calibration is switched on after reset.
// - Each 16-bit threshold is written one byte at a time and the bytes form one value.
// - Calibration threshold codes 0 to 16384 map linearly onto average magnitude, top code at full scale.
// - A 4-bit test mode picks pass-through, zero, positive or negative full scale, all format dependent.
// - Checkerboard, word toggle and ramp ignore the format; the long pseudo-random sequence obeys it.
// - User mode outputs the programmed user words in place of data, subject to the format.
// - Pulling the active-low chip reset returns all logic to its default state.
package adc_backend_pkg;

    localparam int ADDR_W = 13;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [12:0] OFF_TEST_SEL = 13'h00D;
    localparam logic [12:0] OFF_USER_FIRST = 13'h019;
    localparam logic [12:0] OFF_USER_LAST = 13'h020;
    localparam logic [12:0] OFF_FD_UPPER_LO = 13'h040;
    localparam logic [12:0] OFF_FD_UPPER_HI = 13'h041;
    localparam logic [12:0] OFF_FD_LOWER_LO = 13'h042;
    localparam logic [12:0] OFF_FD_LOWER_HI = 13'h043;
    localparam logic [12:0] OFF_FD_DWELL_LO = 13'h044;
    localparam logic [12:0] OFF_FD_DWELL_HI = 13'h045;
    localparam logic [12:0] OFF_CAL_THR_LO = 13'h046;
    localparam logic [12:0] OFF_CAL_THR_HI = 13'h047;
    localparam logic [12:0] OFF_CAL_CTRL = 13'h048;
    localparam logic [12:0] OFF_FORMAT = 13'h049;
    localparam logic [12:0] OFF_STATUS = 13'h04A;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0] TEST_SEL_RESET = 8'h00;
    localparam logic [7:0] CAL_CTRL_RESET = 8'h01;
    localparam logic [7:0] FORMAT_RESET = 8'h00;
    localparam logic [15:0] FD_UPPER_RESET = 16'h0700;
    localparam logic [15:0] FD_LOWER_RESET = 16'h0600;
    localparam logic [15:0] FD_DWELL_RESET = 16'h0010;
    localparam logic [15:0] CAL_THR_RESET = 16'h1000;
    localparam int CAL_GATE_BIT = 0;
    localparam int FMT_OFFSET_BIT = 0;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_BLOCKED_BIT = 1;

    // ****************************************
    // Test modes and patterns
    // ****************************************
    localparam logic [3:0] TM_OFF = 4'h0;
    localparam logic [3:0] TM_MID = 4'h1;
    localparam logic [3:0] TM_POS_FS = 4'h2;
    localparam logic [3:0] TM_NEG_FS = 4'h3;
    localparam logic [3:0] TM_CHECKER = 4'h4;
    localparam logic [3:0] TM_PN_LONG = 4'h5;
    localparam logic [3:0] TM_TOGGLE = 4'h7;
    localparam logic [3:0] TM_USER = 4'h8;
    localparam logic [3:0] TM_RAMP = 4'hF;
    localparam logic [11:0] PAT_ZERO = 12'h000;
    localparam logic [11:0] PAT_POS_FS = 12'h7FF;
    localparam logic [11:0] PAT_NEG_FS = 12'h800;
    localparam logic [11:0] PAT_CHECK_A = 12'hAAA;
    localparam logic [11:0] PAT_CHECK_B = 12'h555;
    localparam logic [11:0] PAT_ONES = 12'hFFF;
    localparam logic [11:0] FMT_FLIP = 12'h800;
    localparam logic [22:0] PN_SEED = 23'h7FFFFF;
    localparam int PN_TAP = 17;

    // Magnitude 2048 times 8 lands on the top threshold code
    localparam logic [15:0] CAL_FULL_SCALE = 16'h4000;
    localparam int CAL_SCALE_SH = 3;

    typedef struct packed {
        logic valid;
        logic [11:0] data;
    } sample_t;

    typedef struct packed {
        logic en;
        logic [12:0] addr;
        logic [7:0] data;
    } reg_wr_t;

endpackage

// *** host_model.sv ***
// Model of the host side: byte writes and register reads.
// Assumes the bench calls its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output adc_backend_pkg::reg_wr_t reg_wr,
    output logic [adc_backend_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [7:0] rd_data
);
    import adc_backend_pkg::*;

    initial begin
        reg_wr = '0;
        rd_addr = '0;
    end

    // ****************************************
    // Access tasks
    // ****************************************
    // One byte per strobe; the device builds wide values itself
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        reg_wr = '{1'b1, a, d};
        @(posedge clk_sys);
        #1;
        reg_wr.en = 1'b0;
        // Idle edge so a following call never re-raises the strobe at once
        @(posedge clk_sys);
        #1;
    endtask

    task automatic wr16(input logic [12:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 13'h001, v[15:8]);
    endtask

    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        rd_addr = a;
        @(posedge clk_sys);
        #1;
        d = rd_data;
    endtask
endmodule
`default_nettype wire

// *** test_adc_backend_detect_cal_testgen.sv ***
// Self-checking bench: detector, calibration gate, pattern generator.
// Assumes host_model owns the register port; samples are driven here.
`timescale 1ns/1ps
`default_nettype none
module test_adc_backend_detect_cal_testgen;
    import adc_backend_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    sample_t sample_in = '0;
    reg_wr_t reg_wr;
    logic [ADDR_W-1:0] rd_addr;
    logic [7:0] rd_data;
    sample_t data_out;
    logic overrange_flag;
    logic cal_update;
    logic [15:0] cal_coeff;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int upd_cnt = 0;
    logic [11:0] o1;
    logic [11:0] o2;
    logic f;
    logic [7:0] b;
    logic [11:0] ov_in [8] = '{12'h700, 12'h8FF, 12'h100, 12'h100,
        12'h600, 12'h100, 12'h100, 12'h100};
    logic ov_exp [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [3:0] fm [3] = '{TM_MID, TM_POS_FS, TM_NEG_FS};
    logic [11:0] fx [3] = '{PAT_ZERO, PAT_POS_FS, PAT_NEG_FS};

    always #2.5 clk_sys = ~clk_sys;

    // Short window keeps each calibration pass to eight samples
    adc_backend_detect_cal_testgen #(.SAMPLE_W(12), .CAL_LOG2_N(3)) DUT (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .sample_in(sample_in),
        .reg_wr(reg_wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .data_out(data_out),
        .overrange_flag(overrange_flag),
        .cal_update(cal_update),
        .cal_coeff(cal_coeff)
    );

    host_model host (
        .clk_sys(clk_sys),
        .reg_wr(reg_wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    always @(posedge clk_sys) begin
        cycles++;
        if (cal_update === 1'b1) upd_cnt++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task wrap_up;
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task rdchk(input logic [12:0] a, input logic [7:0] e);
        host.rd(a, b);
        chk({8'h00, b}, {8'h00, e});
    endtask

    // One sample, then wait a bounded time for its output slot
    task xfer(input logic [11:0] d, output logic [11:0] o, output logic fl);
        int n;
        sample_in = '{1'b1, d};
        @(posedge clk_sys);
        #1;
        sample_in.valid = 1'b0;
        n = 0;
        while (data_out.valid !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk({15'h0000, data_out.valid}, 16'h0001);
        o = data_out.data;
        fl = overrange_flag;
        @(posedge clk_sys);
        #1;
    endtask

    task alt(input logic [3:0] m, input logic [11:0] w);
        host.wr(OFF_TEST_SEL, {4'h0, m});
        xfer(12'h123, o1, f);
        xfer(12'h123, o2, f);
        chk({4'h0, o1 ^ o2}, 16'h0FFF);
        chk({15'h0000, (o1 === w) || (o1 === ~w)}, 16'h0001);
    endtask

    // Signs alternate so the magnitude path is exercised both ways
    task win(input logic [11:0] m);
        for (int k = 0; k < 8; k++) begin
            xfer((k % 2) ? (~m + 12'h001) : m, o1, f);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        rdchk(OFF_TEST_SEL, 8'h00);
        rdchk(OFF_CAL_CTRL, 8'h01);
        rdchk(OFF_FD_UPPER_HI, 8'h07);
        rdchk(13'h100, 8'h00);
        host.wr16(OFF_FD_DWELL_LO, 16'h0002);
        rdchk(OFF_FD_DWELL_LO, 8'h02);
        for (int i = 0; i < 8; i++) begin
            xfer(ov_in[i], o1, f);
            chk({4'h0, o1}, {4'h0, ov_in[i]});
            chk({15'h0000, f}, {15'h0000, ov_exp[i]});
        end
        for (int i = 0; i < 3; i++) begin
            host.wr(OFF_TEST_SEL, {4'h0, fm[i]});
            xfer(12'h123, o1, f);
            chk({4'h0, o1}, {4'h0, fx[i]});
        end
        alt(TM_CHECKER, PAT_CHECK_A);
        alt(TM_TOGGLE, PAT_ONES);
        host.wr(OFF_TEST_SEL, {4'h0, TM_RAMP});
        rdchk(OFF_TEST_SEL, 8'h0F);
        xfer(12'h123, o1, f);
        xfer(12'h123, o2, f);
        chk({4'h0, o2}, {4'h0, o1 + 12'h001});
        host.wr(OFF_TEST_SEL, {4'h0, TM_PN_LONG});
        xfer(12'h123, o1, f);
        xfer(12'h123, o2, f);
        chk({15'h0000, o1 !== o2}, 16'h0001);
        host.wr(OFF_FORMAT, 8'h01);
        alt(TM_CHECKER, PAT_CHECK_A);
        host.wr(OFF_TEST_SEL, {4'h0, TM_POS_FS});
        xfer(12'h123, o1, f);
        chk({4'h0, o1}, 16'h0FFF);
        for (int k = 0; k < 8; k++) begin
            host.wr(OFF_USER_FIRST + 13'(k), (k % 2) ? 8'hA5 : 8'h50);
        end
        host.wr(OFF_TEST_SEL, {4'h0, TM_USER});
        xfer(12'h123, o1, f);
        chk({4'h0, o1}, 16'h0255);
        host.wr(OFF_FORMAT, 8'h00);
        xfer(12'h123, o1, f);
        chk({4'h0, o1}, 16'h0A55);
        // Second reset in mid-run, then calibration from a clean window
        rstn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        upd_cnt = 0;
        chk({15'h0000, overrange_flag}, 16'h0000);
        rdchk(OFF_FD_DWELL_LO, 8'h10);
        win(12'h400);
        chk(16'(upd_cnt), 16'h0001);
        chk(cal_coeff, 16'h2000);
        host.wr16(OFF_CAL_THR_LO, 16'h0800);
        win(12'h100);
        chk(16'(upd_cnt), 16'h0001);
        chk(cal_coeff, 16'h2000);
        rdchk(OFF_STATUS, 8'h02);
        host.wr(OFF_CAL_CTRL, 8'h00);
        win(12'h100);
        chk(16'(upd_cnt), 16'h0002);
        chk(cal_coeff, 16'h0800);
        wrap_up();
    end
endmodule
`default_nettype wire
